// [cmbaf_pkg.sv]
// constants, register map and types for the can mode, bit rate and acceptance filter block
package cmbaf_pkg;
	localparam int          ADDR_W        = 12;
	localparam int          MB_COUNT      = 32;
	localparam int          MASK_COUNT    = 8;
	localparam int          ID_W          = 29;
	// register byte offsets
	localparam logic [11:0] OFF_CTRL      = 12'h000;
	localparam logic [11:0] OFF_STATUS    = 12'h004;
	localparam logic [11:0] OFF_CLKCFG    = 12'h008;
	localparam logic [11:0] OFF_BITCFG    = 12'h00C;
	localparam logic [11:0] OFF_TEST      = 12'h010;
	localparam logic [11:0] OFF_ERRFLAG   = 12'h014;
	localparam logic [11:0] OFF_REC       = 12'h018;
	localparam logic [11:0] OFF_TEC       = 12'h01C;
	localparam logic [11:0] OFF_TSTAMP    = 12'h020;
	localparam logic [11:0] OFF_MKINV     = 12'h024;
	localparam logic [11:0] OFF_RXEN      = 12'h028;
	localparam logic [11:0] OFF_FIDC0     = 12'h060;
	localparam logic [11:0] OFF_FIDC1     = 12'h064;
	localparam logic [6:0]  MASK_PAGE     = 7'h02;
	localparam logic [4:0]  MB_PAGE       = 5'h02;
	// control register fields
	localparam int          CTL_SLEEP     = 0;
	localparam int          CTL_MODE_LO   = 1;
	localparam int          CTL_BOM_LO    = 3;
	localparam int          CTL_FBR       = 5;
	localparam int          CTL_ID_FORMAT_MODE_LO   = 6;
	localparam int          CTL_FIFO      = 8;
	// status register fields
	localparam int          ST_RESET      = 0;
	localparam int          ST_HALT       = 1;
	localparam int          ST_SLEEP      = 2;
	localparam int          ST_BUSOFF     = 3;
	localparam int          ST_RX         = 4;
	localparam int          ST_TX         = 5;
	localparam int          ST_ACTIVE     = 6;
	// error flag fields
	localparam int          EF_BOENTRY    = 0;
	localparam int          EF_BORECOV    = 1;
	// bit config fields: prescaler [9:0], seg1 [19:16], seg2 [26:24]
	localparam int          BC_SEG1_LO    = 16;
	localparam int          BC_SEG2_LO    = 24;
	// mailbox id word fields
	localparam int          MB_IDE_BIT    = 29;
	localparam int          MB_RTR_BIT    = 30;
	localparam logic [28:0] STD_ID_MASK   = 29'h1FFC0000;
	// mode encodings
	localparam logic [1:0]  MODE_OP       = 2'h0;
	localparam logic [1:0]  MODE_RST      = 2'h1;
	localparam logic [1:0]  MODE_HLT      = 2'h2;
	localparam logic [1:0]  BOM_NORMAL    = 2'h0;
	localparam logic [1:0]  BOM_HALT_ENT  = 2'h1;
	localparam logic [1:0]  BOM_HALT_END  = 2'h2;
	localparam logic [1:0]  BOM_HALT_PROG = 2'h3;
	localparam logic [1:0]  ID_FORMAT_MODE_EXT      = 2'h1;
	localparam logic [1:0]  ID_FORMAT_MODE_MIXED    = 2'h2;
	// counting constants
	localparam logic [3:0]  IDLE_BITS     = 4'hB;
	localparam logic [7:0]  RECOV_RUNS    = 8'h80;
	localparam logic [8:0]  TEC_BUSOFF    = 9'h100;
	localparam logic [7:0]  ERR_TX_STEP   = 8'h08;
	localparam logic [31:0] CTRL_RESET    = 32'h00000003;
	typedef enum logic [1:0] {
		CMBAF_MODE_OPER,
		CMBAF_MODE_RESET,
		CMBAF_MODE_HALT
	} cmbaf_mode_e;
	typedef enum logic [1:0] {
		CMBAF_SUB_IDLE,
		CMBAF_SUB_RX,
		CMBAF_SUB_TX
	} cmbaf_sub_e;
endpackage : cmbaf_pkg

// [cmbaf_top.sv]
// can controller core: modes, bus-off recovery, bit timing and acceptance filtering
`timescale 1ns/10ps
module cmbaf_top (
	input  wire logic                          pclk,
	input  wire logic                          presetn,
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [cmbaf_pkg::ADDR_W-1:0]  paddr,
	input  wire logic [31:0]                   pwdata,
	output logic      [31:0]                   prdata,
	output logic                               pready,
	output logic                               pslverr,
	input  wire logic                          can_rx,
	input  wire logic                          frame_rx_active,
	input  wire logic                          frame_tx_active,
	input  wire logic                          tx_error_evt,
	input  wire logic                          rx_error_evt,
	input  wire logic                          tx_success_evt,
	input  wire logic                          rx_success_evt,
	input  wire logic                          rx_frame_valid,
	input  wire logic [cmbaf_pkg::ID_W-1:0]    rx_frame_id,
	input  wire logic                          rx_frame_ide,
	input  wire logic                          rx_frame_rtr,
	output logic                               module_clock_en,
	output logic                               bus_active,
	output logic                               bit_sample,
	output cmbaf_pkg::cmbaf_sub_e              sub_state,
	output logic                               self_receive,
	output logic                               accept_valid,
	output logic                               accept_fifo,
	output logic      [4:0]                    accept_mailbox
);
	import cmbaf_pkg::*;

	logic [31:0]       ctrl_r;
	logic [1:0]        clksel_r;
	logic [31:0]       bitcfg_r;
	logic [1:0]        test_r;
	logic [1:0]        errflag_r;
	logic [7:0]        rec_r;
	logic [8:0]        tec_r;
	logic [15:0]       tstamp_r;
	logic [31:0]       mkinv_r;
	logic [31:0]       rxen_r;
	logic [ID_W-1:0]   mask_r [MASK_COUNT];
	logic [30:0]       fidc_r [2];
	logic [30:0]       mb_r   [MB_COUNT];
	cmbaf_mode_e       mode_r;
	logic              sleep_r;
	logic              busoff_r;
	logic              active_r;
	logic [3:0]        idle_cnt_r;
	logic [7:0]        recov_cnt_r;
	logic [9:0]        presc_cnt_r;
	logic              half_r;
	logic [4:0]        tq_cnt_r;
	logic [31:0]       rdata_nxt;
	logic              rvalid_nxt;
	logic              wr;
	logic              setup;
	logic              run;
	logic              src_en;
	logic              tq_en;
	logic              auto_halt;
	logic              bo_enter;
	logic              recov_done;
	logic              force_ret;
	logic              prog_halt;
	logic [1:0]        mode_sel;
	logic [1:0]        busoff_recovery_policy;
	logic [4:0]        seg_end;
	logic [4:0]        samp_pt;
	logic              hit;
	logic [4:0]        hit_idx;
	logic              fifo_hit;

	// one compare set against a received frame; fifo sets pass mixed mode
	function automatic logic id_match(input logic [ID_W-1:0] fid, input logic fide, input logic frtr,
	                                  input logic [30:0] cmp, input logic [ID_W-1:0] mask,
	                                  input logic use_mask, input logic [1:0] id_format_mode);
		logic            cide;
		logic [ID_W-1:0] m;
		cide = (id_format_mode == ID_FORMAT_MODE_MIXED) ? cmp[MB_IDE_BIT] : (id_format_mode == ID_FORMAT_MODE_EXT);
		m = use_mask ? mask : '1;
		if (!cide) begin
			m = m & STD_ID_MASK;
		end
		id_match = (fide == cide) && (frtr == cmp[MB_RTR_BIT]) && (((fid ^ cmp[ID_W-1:0]) & m) == '0);
	endfunction : id_match

	assign mode_sel = ctrl_r[CTL_MODE_LO +: 2];
	assign busoff_recovery_policy      = ctrl_r[CTL_BOM_LO +: 2];
	assign setup    = psel && !penable;
	assign wr       = psel && penable && pwrite;
	assign pready   = penable;
	assign run      = !sleep_r;
	assign module_clock_en = run;
	assign bus_active      = active_r;
	assign force_ret = wr && !sleep_r && paddr == OFF_CTRL && pwdata[CTL_FBR] && busoff_r;
	assign prog_halt = busoff_r && busoff_recovery_policy == BOM_HALT_PROG && mode_sel == MODE_HLT;
	assign auto_halt = run && mode_r == CMBAF_MODE_OPER && mode_sel != MODE_RST &&
	                   ((bo_enter && busoff_recovery_policy == BOM_HALT_ENT) || (recov_done && busoff_recovery_policy == BOM_HALT_END));

	// register writes; in sleep only the sleep bit may change
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r   <= CTRL_RESET;
			clksel_r <= '0;
			bitcfg_r <= '0;
			test_r   <= '0;
			mkinv_r  <= '0;
			rxen_r   <= '0;
		end else if (wr && sleep_r) begin
			if (paddr == OFF_CTRL) begin
				ctrl_r[CTL_SLEEP] <= pwdata[CTL_SLEEP];
			end
		end else if (wr) begin
			case (paddr)
				OFF_CTRL: begin
					ctrl_r <= {23'h0, pwdata[8:0]};
					ctrl_r[CTL_FBR] <= 1'b0;
				end
				OFF_CLKCFG: clksel_r <= pwdata[1:0];
				OFF_BITCFG: bitcfg_r <= pwdata;
				OFF_TEST: test_r <= pwdata[1:0];
				OFF_MKINV: mkinv_r <= pwdata;
				OFF_RXEN: rxen_r <= pwdata;
				default: begin
				end
			endcase
			// a hardware halt outranks a same-cycle write, else mode select would undo it
			if (auto_halt) begin
				ctrl_r[CTL_MODE_LO +: 2] <= MODE_HLT;
			end
		end else if (auto_halt) begin
			ctrl_r[CTL_MODE_LO +: 2] <= MODE_HLT;
		end else if (mode_r == CMBAF_MODE_RESET) begin
			test_r <= '0;
		end
	end

	// mask, fifo compare and mailbox id words survive every mode change
	always_ff @(posedge pclk) begin
		if (wr && !sleep_r) begin
			if (paddr[11:5] == MASK_PAGE) begin
				mask_r[paddr[4:2]] <= pwdata[ID_W-1:0];
			end
			if (paddr == OFF_FIDC0) begin
				fidc_r[0] <= pwdata[30:0];
			end
			if (paddr == OFF_FIDC1) begin
				fidc_r[1] <= pwdata[30:0];
			end
			if (paddr[11:7] == MB_PAGE) begin
				mb_r[paddr[6:2]] <= pwdata[30:0];
			end
		end
	end

	// sleep follows its request bit; the module clock stops in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sleep_r <= 1'b1;
		end else begin
			sleep_r <= ctrl_r[CTL_SLEEP];
		end
	end

	// mode machine; ordinary halt waits for bus-off to end, reset does not
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_r <= CMBAF_MODE_RESET;
		end else if (run) begin
			case (mode_r)
				CMBAF_MODE_OPER: begin
					if (mode_sel == MODE_RST) begin
						mode_r <= CMBAF_MODE_RESET;
					end else if (bo_enter && busoff_recovery_policy == BOM_HALT_ENT) begin
						mode_r <= CMBAF_MODE_HALT;
					end else if (prog_halt) begin
						mode_r <= CMBAF_MODE_HALT;
					end else if (recov_done && busoff_recovery_policy == BOM_HALT_END) begin
						mode_r <= CMBAF_MODE_HALT;
					end else if (mode_sel == MODE_HLT && !busoff_r) begin
						mode_r <= CMBAF_MODE_HALT;
					end
				end
				CMBAF_MODE_RESET, CMBAF_MODE_HALT: begin
					case (mode_sel)
						MODE_OP: mode_r <= CMBAF_MODE_OPER;
						MODE_RST: mode_r <= CMBAF_MODE_RESET;
						MODE_HLT: mode_r <= CMBAF_MODE_HALT;
						default: mode_r <= mode_r;
					endcase
				end
				default: mode_r <= CMBAF_MODE_RESET;
			endcase
		end
	end

	// quantum tick: source select, then prescaler of value plus one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			half_r      <= 1'b0;
			presc_cnt_r <= '0;
		end else if (run) begin
			half_r <= !half_r;
			if (src_en) begin
				presc_cnt_r <= (presc_cnt_r >= bitcfg_r[9:0]) ? 10'h000 : presc_cnt_r + 10'h001;
			end
		end
	end
	assign src_en = clksel_r[0] ? half_r : 1'b1;
	assign tq_en  = run && src_en && presc_cnt_r >= bitcfg_r[9:0];

	// sync quantum, then seg1+1 quanta, then seg2+1 quanta
	assign samp_pt = 5'({1'b0, bitcfg_r[BC_SEG1_LO +: 4]} + 5'h01);
	assign seg_end = 5'(samp_pt + {2'b00, bitcfg_r[BC_SEG2_LO +: 3]} + 5'h01);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tq_cnt_r   <= '0;
			bit_sample <= 1'b0;
		end else begin
			bit_sample <= tq_en && tq_cnt_r == samp_pt;
			if (tq_en) begin
				tq_cnt_r <= (tq_cnt_r >= seg_end) ? 5'h00 : tq_cnt_r + 5'h01;
			end
		end
	end

	// idle-bit counting for joining the bus and for bus-off recovery
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			idle_cnt_r  <= '0;
			recov_cnt_r <= '0;
			active_r    <= 1'b0;
		end else if (mode_r != CMBAF_MODE_OPER || sleep_r || force_ret || bo_enter) begin
			idle_cnt_r  <= '0;
			recov_cnt_r <= '0;
			active_r    <= 1'b0;
		end else if (bit_sample) begin
			if (!can_rx) begin
				idle_cnt_r <= '0;
			end else if (idle_cnt_r == IDLE_BITS - 4'h1) begin
				idle_cnt_r <= '0;
				if (busoff_r) begin
					recov_cnt_r <= recov_cnt_r + 8'h01;
				end else begin
					active_r <= 1'b1;
				end
			end else begin
				idle_cnt_r <= idle_cnt_r + 4'h1;
			end
		end else if (recov_done) begin
			recov_cnt_r <= '0;
			active_r    <= 1'b1;
		end
	end
	assign recov_done = busoff_r && recov_cnt_r == RECOV_RUNS && mode_r == CMBAF_MODE_OPER;
	assign bo_enter   = active_r && !busoff_r && tec_r >= TEC_BUSOFF;

	// bus-off state; a halt from bus-off returns error-active
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busoff_r <= 1'b0;
		end else if (mode_r == CMBAF_MODE_RESET || force_ret || recov_done || prog_halt) begin
			busoff_r <= 1'b0;
		end else if (bo_enter && busoff_recovery_policy != BOM_HALT_ENT) begin
			busoff_r <= 1'b1;
		end
	end

	// error counters run only as an active node; cleared by reset mode and recovery
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rec_r <= '0;
			tec_r <= '0;
		end else if (mode_r == CMBAF_MODE_RESET || force_ret || recov_done || prog_halt ||
		             (bo_enter && busoff_recovery_policy == BOM_HALT_ENT)) begin
			rec_r <= '0;
			tec_r <= '0;
		end else if (active_r && !busoff_r) begin
			if (rx_error_evt && rec_r != 8'hFF) begin
				rec_r <= rec_r + 8'h01;
			end else if (rx_success_evt && rec_r != 8'h00) begin
				rec_r <= rec_r - 8'h01;
			end
			if (tx_error_evt) begin
				tec_r <= tec_r + {1'b0, ERR_TX_STEP};
			end else if (tx_success_evt && tec_r != 9'h000) begin
				tec_r <= tec_r - 9'h001;
			end
		end
	end

	// error flags: write zero clears, a new event in the same cycle wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			errflag_r <= '0;
		end else if (mode_r == CMBAF_MODE_RESET) begin
			errflag_r <= '0;
		end else begin
			errflag_r <= (wr && !sleep_r && paddr == OFF_ERRFLAG) ? (errflag_r & pwdata[1:0]) : errflag_r;
			if (bo_enter) begin
				errflag_r[EF_BOENTRY] <= 1'b1;
			end
			if (recov_done) begin
				errflag_r[EF_BORECOV] <= 1'b1;
			end
		end
	end

	// timestamp counts bit times in operation
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tstamp_r <= '0;
		end else if (mode_r == CMBAF_MODE_RESET) begin
			tstamp_r <= '0;
		end else if (bit_sample && mode_r == CMBAF_MODE_OPER) begin
			tstamp_r <= tstamp_r + 16'h0001;
		end
	end

	// sub-state; transmit wins when both engines report activity
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sub_state    <= CMBAF_SUB_IDLE;
			self_receive <= 1'b0;
		end else begin
			sub_state <= (!active_r || busoff_r) ? CMBAF_SUB_IDLE :
			             frame_tx_active ? CMBAF_SUB_TX :
			             frame_rx_active ? CMBAF_SUB_RX : CMBAF_SUB_IDLE;
			self_receive <= active_r && frame_tx_active && test_r[1];
		end
	end

	// lowest numbered matching mailbox wins; fifo slots never match singly
	always_comb begin
		hit      = 1'b0;
		hit_idx  = '0;
		fifo_hit = 1'b0;
		for (int i = MB_COUNT - 1; i >= 0; i--) begin
			if (rxen_r[i] && !(ctrl_r[CTL_FIFO] && i >= 24) &&
			    id_match(rx_frame_id, rx_frame_ide, rx_frame_rtr, mb_r[i], mask_r[i / 4], !mkinv_r[i],
			             ctrl_r[CTL_ID_FORMAT_MODE_LO +: 2])) begin
				hit     = 1'b1;
				hit_idx = 5'(i);
			end
		end
		if (ctrl_r[CTL_FIFO]) begin
			fifo_hit = id_match(rx_frame_id, rx_frame_ide, rx_frame_rtr, fidc_r[0], mask_r[6], 1'b1, ID_FORMAT_MODE_MIXED) ||
			           id_match(rx_frame_id, rx_frame_ide, rx_frame_rtr, fidc_r[1], mask_r[7], 1'b1, ID_FORMAT_MODE_MIXED);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			accept_valid   <= 1'b0;
			accept_fifo    <= 1'b0;
			accept_mailbox <= '0;
		end else begin
			accept_valid <= rx_frame_valid && active_r && !busoff_r && (hit || fifo_hit);
			if (rx_frame_valid) begin
				accept_fifo    <= !hit && fifo_hit;
				accept_mailbox <= hit ? hit_idx : 5'h1C;
			end
		end
	end

	// read data captured in the setup cycle; reads work in sleep too
	always_comb begin
		rdata_nxt  = '0;
		rvalid_nxt = 1'b1;
		case (paddr)
			OFF_CTRL: rdata_nxt = ctrl_r;
			OFF_STATUS: begin
				rdata_nxt[ST_RESET]  = mode_r == CMBAF_MODE_RESET;
				rdata_nxt[ST_HALT]   = mode_r == CMBAF_MODE_HALT;
				rdata_nxt[ST_SLEEP]  = sleep_r;
				rdata_nxt[ST_BUSOFF] = busoff_r;
				rdata_nxt[ST_RX]     = sub_state == CMBAF_SUB_RX;
				rdata_nxt[ST_TX]     = sub_state == CMBAF_SUB_TX;
				rdata_nxt[ST_ACTIVE] = active_r;
			end
			OFF_CLKCFG: rdata_nxt = {30'h0, clksel_r};
			OFF_BITCFG: rdata_nxt = bitcfg_r;
			OFF_TEST: rdata_nxt = {30'h0, test_r};
			OFF_ERRFLAG: rdata_nxt = {30'h0, errflag_r};
			OFF_REC: rdata_nxt = {24'h0, rec_r};
			OFF_TEC: rdata_nxt = {23'h0, tec_r};
			OFF_TSTAMP: rdata_nxt = {16'h0, tstamp_r};
			OFF_MKINV: rdata_nxt = mkinv_r;
			OFF_RXEN: rdata_nxt = rxen_r;
			OFF_FIDC0: rdata_nxt = {1'b0, fidc_r[0]};
			OFF_FIDC1: rdata_nxt = {1'b0, fidc_r[1]};
			default: begin
				if (paddr[11:5] == MASK_PAGE) begin
					rdata_nxt = {3'h0, mask_r[paddr[4:2]]};
				end else if (paddr[11:7] == MB_PAGE) begin
					rdata_nxt = {1'b0, mb_r[paddr[6:2]]};
				end else begin
					rvalid_nxt = 1'b0;
				end
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= '0;
			pslverr <= 1'b0;
		end else if (setup) begin
			prdata  <= pwrite ? 32'h00000000 : rdata_nxt;
			pslverr <= !rvalid_nxt;
		end
	end
endmodule : cmbaf_top

// [cmbaf_chk.sv]
// concurrent checks on the mode, bit timing and filter ports of the can core
`timescale 1ns/10ps
module cmbaf_chk (
	input wire logic                         pclk,
	input wire logic                         presetn,
	input wire logic                         psel,
	input wire logic                         penable,
	input wire logic                         pwrite,
	input wire logic [cmbaf_pkg::ADDR_W-1:0] paddr,
	input wire logic                         can_rx,
	input wire logic                         frame_tx_active,
	input wire logic                         rx_frame_valid,
	input wire logic                         module_clock_en,
	input wire logic                         bus_active,
	input wire logic                         bit_sample,
	input cmbaf_pkg::cmbaf_sub_e             sub_state,
	input wire logic                         self_receive,
	input wire logic                         accept_valid,
	input wire logic                         accept_fifo,
	input wire logic [4:0]                   accept_mailbox
);
	import cmbaf_pkg::*;
	logic [3:0] rec_run_r;
	logic       ctrl_wr;
	assign ctrl_wr = psel && penable && pwrite && paddr == OFF_CTRL;
	// saturating run of recessive samples; one dominant sample restarts it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rec_run_r <= 4'h0;
		end else if (bit_sample) begin
			rec_run_r <= !can_rx ? 4'h0 : rec_run_r + {3'h0, rec_run_r != 4'hF};
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_asleep_after_reset: assert property ($rose(presetn) |-> !module_clock_en) else $error("clock on after reset");
	a_clock_by_write: assert property ($changed(module_clock_en) |-> $past(ctrl_wr) || $past(ctrl_wr, 2))
		else $error("module clock changed without control write");
	a_sleep_quiet: assert property (!module_clock_en |-> !bus_active) else $error("active node while asleep");
	a_join_after_idle: assert property ($rose(bus_active) |-> rec_run_r >= IDLE_BITS) else $error("joined bus early");
	a_accept_cause: assert property (accept_valid |-> $past(rx_frame_valid) && $past(bus_active))
		else $error("acceptance without frame or inactive");
	a_fifo_slot: assert property (accept_valid && accept_fifo |-> accept_mailbox == 5'h1C) else $error("fifo index wrong");
	a_self_needs_tx: assert property (self_receive |-> $past(frame_tx_active) && $past(bus_active))
		else $error("self receive without transmit");
	a_tx_substate: assert property (sub_state == CMBAF_SUB_TX |-> $past(frame_tx_active)) else $error("tx state without tx");
	a_sample_gap: assert property (bit_sample |=> !bit_sample [*2]) else $error("sample points too close");
	c_accept: cover property (accept_valid && !accept_fifo);
	c_join: cover property ($rose(bus_active));
	c_self: cover property (self_receive);
	c_wake: cover property ($rose(module_clock_en));
endmodule : cmbaf_chk

bind cmbaf_top cmbaf_chk cmbaf_chk_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .can_rx(can_rx), .frame_tx_active(frame_tx_active),
	.rx_frame_valid(rx_frame_valid), .module_clock_en(module_clock_en), .bus_active(bus_active),
	.bit_sample(bit_sample), .sub_state(sub_state), .self_receive(self_receive), .accept_valid(accept_valid),
	.accept_fifo(accept_fifo), .accept_mailbox(accept_mailbox));

// [cmbaf_bus_model.sv]
// far side of the can bus: recessive by pull-up unless the bench holds it dominant
`timescale 1ns/10ps
module cmbaf_bus_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic bit_sample,
	input wire logic dominant,
	output logic     can_rx
);
	// level moves only just after a sample point, like a real bit boundary
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			can_rx <= 1'b1;
		end else if (bit_sample) begin
			can_rx <= !dominant;
		end
	end
endmodule : cmbaf_bus_model

// [tb_cmbaf_top.sv]
// self-checking bench for the can mode, bit rate and acceptance filter core
`timescale 1ns/10ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin error_cnt++; $display("[ERR] %0t got %0h exp %0h", $time, a, b); end end
module tb_cmbaf_top;
	import cmbaf_pkg::*;
	typedef struct packed {logic w; logic [11:0] a; logic [31:0] d; logic e;} cmbaf_row_s;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic        pready, pslverr, e, can_rx, dominant = 1'b1, frame_tx = 1'b0, tx_err = 1'b0, frame_rx = 1'b0;
	logic        rx_valid = 1'b0, clk_en, bus_active, bit_sample, self_rx, acc_valid, acc_fifo;
	logic [28:0] rx_id = 29'h0;
	logic [4:0]  acc_mb;
	cmbaf_sub_e  sub_state;
	int          error_cnt = 0;
	int          total_checks = 0;
	int          n;
	cmbaf_row_s  rows [22] = '{'{1'b0, OFF_CTRL, 32'h3, 1'b0}, '{1'b0, OFF_STATUS, 32'h5, 1'b0},
		'{1'b1, OFF_CTRL, 32'h2, 1'b0}, '{1'b0, OFF_STATUS, 32'h1, 1'b0}, '{1'b1, OFF_BITCFG, 32'h10001, 1'b0},
		'{1'b1, OFF_CLKCFG, 32'h0, 1'b0}, '{1'b1, 12'h040, 32'h1FFC0000, 1'b0}, '{1'b1, 12'h104, 32'h2AC0000, 1'b0},
		'{1'b1, OFF_RXEN, 32'h3, 1'b0}, '{1'b1, OFF_CTRL, 32'h3, 1'b0}, '{1'b1, OFF_BITCFG, 32'h5, 1'b0},
		'{1'b0, OFF_STATUS, 32'h5, 1'b0}, '{1'b0, OFF_BITCFG, 32'h10001, 1'b0}, '{1'b1, OFF_CTRL, 32'h2, 1'b0},
		'{1'b0, 12'h040, 32'h1FFC0000, 1'b0}, '{1'b0, 12'hFFC, 32'h0, 1'b1},
		'{1'b1, 12'h058, 32'h1FFC0000, 1'b0}, '{1'b1, 12'h05C, 32'h1FFC0000, 1'b0},
		'{1'b1, OFF_FIDC0, 32'h3000000, 1'b0}, '{1'b1, OFF_FIDC1, 32'h3000000, 1'b0},
		'{1'b1, OFF_CTRL, 32'h108, 1'b0}, '{1'b0, OFF_STATUS, 32'h0, 1'b0}};
	always #5 pclk = ~pclk;
	cmbaf_top cmbaf_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .can_rx(can_rx),
		.frame_rx_active(frame_rx), .frame_tx_active(frame_tx), .tx_error_evt(tx_err), .rx_error_evt(1'b0),
		.tx_success_evt(1'b0), .rx_success_evt(1'b0), .rx_frame_valid(rx_valid), .rx_frame_id(rx_id),
		.rx_frame_ide(1'b0), .rx_frame_rtr(1'b0), .module_clock_en(clk_en), .bus_active(bus_active),
		.bit_sample(bit_sample), .sub_state(sub_state), .self_receive(self_rx), .accept_valid(acc_valid),
		.accept_fifo(acc_fifo), .accept_mailbox(acc_mb));
	cmbaf_bus_model cmbaf_bus_model_i (.pclk(pclk), .presetn(presetn), .bit_sample(bit_sample),
		.dominant(dominant), .can_rx(can_rx));
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd,
		output logic er);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (k = 0; k < 20; k++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// idle edge lets mode status settle before the next access
		@(posedge pclk);
	endtask : apb
	task automatic frame(input logic [28:0] id, input logic v, input logic [5:0] fm);
		@(posedge pclk);
		rx_valid <= 1'b1;
		rx_id <= id;
		@(posedge pclk);
		rx_valid <= 1'b0;
		@(negedge pclk);
		`CHK(acc_valid, v)
		if (v) `CHK({acc_fifo, acc_mb}, fm)
	endtask : frame
	task automatic next_sample(output int k);
		for (k = 1; k < 100 && bit_sample !== 1'b1; k++) @(negedge pclk);
		@(negedge pclk);
	endtask : next_sample
	task finish_test;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : finish_test
	initial begin
		#50000;
		error_cnt++;
		finish_test();
	end
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(negedge pclk);
		`CHK(clk_en, 1'b0)
		foreach (rows[i]) begin
			apb(rows[i].w, rows[i].a, rows[i].d, q, e);
			`CHK(e, rows[i].e)
			if (!rows[i].w && !rows[i].e) `CHK(q, rows[i].d)
		end
		// release the bus: ten samples can never make eleven recessive bits
		dominant <= 1'b0;
		repeat (10) next_sample(n);
		`CHK(bus_active, 1'b0)
		repeat (3) next_sample(n);
		`CHK(bus_active, 1'b1)
		next_sample(n);
		`CHK(n, 8)
		frame(29'h02AC0123, 1'b1, 6'h01);
		frame(29'h02B00000, 1'b0, 6'h00);
		// widened mask ignores the low standard bits, mask invalid brings them back
		apb(1'b1, 12'h040, 32'h1FE00000, q, e);
		frame(29'h02B00000, 1'b1, 6'h01);
		apb(1'b1, OFF_MKINV, 32'h2, q, e);
		frame(29'h02B00000, 1'b0, 6'h00);
		frame(29'h03000000, 1'b1, 6'h3C);
		apb(1'b1, OFF_TEST, 32'h2, q, e);
		frame_tx <= 1'b1;
		repeat (2) @(negedge pclk);
		`CHK(self_rx, 1'b1)
		`CHK(sub_state, CMBAF_SUB_TX)
		@(posedge pclk);
		frame_tx <= 1'b0;
		frame_rx <= 1'b1;
		repeat (2) @(negedge pclk);
		`CHK(sub_state, CMBAF_SUB_RX)
		`CHK(self_rx, 1'b0)
		@(posedge pclk);
		frame_rx <= 1'b0;
		repeat (32) begin
			@(posedge pclk);
			tx_err <= 1'b1;
			@(posedge pclk);
			tx_err <= 1'b0;
		end
		repeat (3) @(negedge pclk);
		`CHK(bus_active, 1'b0)
		apb(1'b0, OFF_STATUS, 32'h0, q, e);
		`CHK(q, 32'h2)
		apb(1'b0, OFF_ERRFLAG, 32'h0, q, e);
		`CHK(q, 32'h1)
		apb(1'b0, OFF_BITCFG, 32'h0, q, e);
		`CHK(q, 32'h10001)
		// half-rate source doubles the bit time; the second sample pair is clean
		apb(1'b1, OFF_CLKCFG, 32'h1, q, e);
		repeat (2) next_sample(n);
		`CHK(n, 16)
		finish_test();
	end
endmodule : tb_cmbaf_top
